// *** src/dcs_pkg.sv ***
package dcs_pkg;
  // ==========================================================
  // Widths and register count
  localparam int WORD_W = 36;
  localparam int ADDR_W = 18;
  localparam int NREG = 16;
  // ==========================================================
  // Instruction field positions
  localparam int OP_LSB = 32;
  localparam int REG_LSB = 28;
  localparam int INV_POS = 27;
  localparam int FLD_LSB = 23;
  localparam int PAD_W = 5;
  // ==========================================================
  // Opcodes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_LOAD_IMM = 4'h1;
  localparam logic [3:0] OP_SLOW_LOAD = 4'h2;
  localparam logic [3:0] OP_COND_LOAD = 4'h3;
  localparam logic [3:0] OP_PUSH = 4'h4;
  localparam logic [3:0] OP_PUSH_MARK = 4'h5;
  localparam logic [3:0] OP_UNSTACK = 4'h6;
  localparam logic [3:0] OP_LOAD_PUSH = 4'h7;
  localparam logic [3:0] OP_LOAD_PUSH_MARK = 4'h8;
  localparam logic [3:0] OP_UNCOND_JUMP = 4'h9;
  localparam logic [3:0] OP_SLOW_JUMP = 4'ha;
  localparam logic [3:0] OP_COND_JUMP = 4'hb;
  localparam logic [3:0] OP_CALL = 4'hc;
  localparam logic [3:0] OP_EXEC_AT = 4'hd;
  // ==========================================================
  // Channel register numbers
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_RAR = 4'h2;
  localparam logic [3:0] REG_RCR = 4'h3;
  localparam logic [3:0] REG_P2 = 4'h4;
  localparam logic [3:0] REG_SR = 4'h5;
  // ==========================================================
  // Mode change marks
  localparam logic [3:0] MK_NONE = 4'h0;
  localparam logic [3:0] MK_UNSTACK = 4'h1;
  localparam logic [3:0] MK_SEQ = 4'h2;
  localparam logic [3:0] MK_EXEC = 4'h3;
  localparam logic [3:0] MK_REPEAT = 4'h4;
  // ==========================================================
  // Reset values and counts
  localparam logic [17:0] RST_REG = 18'h00000;
  localparam logic [17:0] ONE = 18'h00001;
  localparam logic [17:0] RCR_LAST = 18'h3ffff;
  localparam logic [4:0] PAD_ZERO = 5'h00;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    FM_SEQ = 4'b0001,
    FM_UNSTACK = 4'b0010,
    FM_EXEC = 4'b0100,
    FM_REPEAT = 4'b1000
  } dcs_fmode_t;
  typedef enum logic [4:0] {
    ST_ISSUE = 5'b00001,
    ST_FWAIT = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_SLOW = 5'b01000,
    ST_PWAIT = 5'b10000
  } dcs_state_t;
endpackage

// *** src/dcs_decode.sv ***
module dcs_decode (
  // Instruction word
  input wire logic [35:0] instr_i,
  // Condition flags
  input wire logic [15:0] cond_i,
  // Fields
  output logic [3:0] op_o,
  output logic [3:0] reg_o,
  output logic [3:0] fld_o,
  output logic [17:0] imm_o,
  output logic cond_ok_o
);
  // ==========================================================
  // Field split
  logic inv;
  logic cond_bit;
  assign op_o = instr_i[dcs_pkg::OP_LSB+:4];
  assign reg_o = instr_i[dcs_pkg::REG_LSB+:4];
  assign fld_o = instr_i[dcs_pkg::FLD_LSB+:4];
  assign imm_o = instr_i[17:0];
  assign inv = instr_i[dcs_pkg::INV_POS];
  // Field doubles as condition select on conditional ops
  assign cond_bit = cond_i[fld_o];
  assign cond_ok_o = cond_bit ^ inv;
endmodule

// *** src/dcs_sequencer.sv ***
module dcs_sequencer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Shared memory port, cycle stolen
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [17:0] mem_addr_o,
  output logic [35:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [35:0] mem_rdata_i,
  // Condition flags, same clock
  input wire logic [15:0] cond_i,
  // Observed state
  output logic [17:0] pc_o,
  output logic [17:0] sp_o,
  output logic [17:0] rar_o,
  output logic [17:0] rcr_o,
  output logic [3:0] fetch_mode_o
);
  // ==========================================================
  // State
  dcs_pkg::dcs_state_t st;
  dcs_pkg::dcs_fmode_t fmode;
  dcs_pkg::dcs_fmode_t next_fmode;
  dcs_pkg::dcs_fmode_t base_mode;
  dcs_pkg::dcs_fmode_t mark_mode;
  logic [35:0] ir;
  logic [17:0] pc;
  logic [17:0] sp;
  logic [17:0] read_address_register;
  logic [17:0] repeat_count_register;
  logic [17:0] p2;
  logic [17:0] last_addr;
  logic [17:0] gen [dcs_pkg::NREG];

  // ==========================================================
  // Decode
  logic [3:0] op;
  logic [3:0] tgt;
  logic [3:0] fld;
  logic [17:0] imm;
  logic cond_ok;

  dcs_decode u_dec (
    .instr_i(ir),
    .cond_i(cond_i),
    .op_o(op),
    .reg_o(tgt),
    .fld_o(fld),
    .imm_o(imm),
    .cond_ok_o(cond_ok)
  );

  // Opcode classes
  logic is_li;
  logic is_lal;
  logic is_lif;
  logic is_psh;
  logic is_push_and_mark;
  logic is_unstk;
  logic is_lp;
  logic is_lpm;
  logic is_jmp;
  logic is_jal;
  logic is_jif;
  logic is_call;
  logic is_execute_at_address;
  logic is_nop;
  assign is_li = op == dcs_pkg::OP_LOAD_IMM;
  assign is_lal = op == dcs_pkg::OP_SLOW_LOAD;
  assign is_lif = op == dcs_pkg::OP_COND_LOAD;
  assign is_psh = op == dcs_pkg::OP_PUSH;
  assign is_push_and_mark = op == dcs_pkg::OP_PUSH_MARK;
  assign is_unstk = op == dcs_pkg::OP_UNSTACK;
  assign is_lp = op == dcs_pkg::OP_LOAD_PUSH;
  assign is_lpm = op == dcs_pkg::OP_LOAD_PUSH_MARK;
  assign is_jmp = op == dcs_pkg::OP_UNCOND_JUMP;
  assign is_jal = op == dcs_pkg::OP_SLOW_JUMP;
  assign is_jif = op == dcs_pkg::OP_COND_JUMP;
  assign is_call = op == dcs_pkg::OP_CALL;
  assign is_execute_at_address = op == dcs_pkg::OP_EXEC_AT;
  assign is_nop = op == dcs_pkg::OP_NOP;

  // ==========================================================
  // Execute controls
  logic in_exec;
  logic fetch_done;
  logic do_load;
  logic do_jump;
  logic do_push;
  logic push_mark;
  logic has_mode;
  logic is_slow;
  logic rcr_more;
  // Slow forms burn one extra cycle
  assign is_slow = is_lal | is_jal;
  assign in_exec = st == dcs_pkg::ST_EXEC;
  assign fetch_done = (st == dcs_pkg::ST_FWAIT) && mem_ack_i;
  // Register load: plain, slow, conditional or after a push
  assign do_load = is_li | is_lal | (is_lif & cond_ok) | is_lp | is_lpm;
  // Counter load: jumps taken, and the call
  assign do_jump = is_jmp | is_jal | (is_jif & cond_ok) | is_call;
  assign do_push = is_psh | is_push_and_mark | is_lp | is_lpm | is_call;
  assign push_mark = is_push_and_mark | is_lpm | is_call;
  // Slow and conditional forms carry no mode field
  assign has_mode = is_li | is_psh | is_push_and_mark | is_lp | is_lpm | is_jmp | is_call | is_nop;
  assign rcr_more = $signed(repeat_count_register) < $signed(dcs_pkg::RCR_LAST);

  // ==========================================================
  // Push word build
  logic [3:0] ptgt;
  logic [17:0] old_val;
  logic [17:0] push_val;
  logic [17:0] push_addr;
  logic [35:0] push_word;
  logic tgt_gen;
  logic ld_pc;
  logic ld_sp;
  logic ld_rar;
  logic ld_rcr;
  logic ld_p2;
  // The call always stacks the counter
  assign ptgt = is_call ? dcs_pkg::REG_PC : tgt;
  assign old_val = (ptgt == dcs_pkg::REG_PC) ? pc :
                   (ptgt == dcs_pkg::REG_SP) ? sp :
                   (ptgt == dcs_pkg::REG_RAR) ? read_address_register :
                   (ptgt == dcs_pkg::REG_RCR) ? repeat_count_register :
                   (ptgt == dcs_pkg::REG_P2) ? p2 : gen[ptgt];
  // Scratch register is overwritten by the new data first
  assign push_val = ((is_lp | is_lpm) && ptgt == dcs_pkg::REG_P2) ? imm : old_val;
  // Pointer reload picks the push address as well
  assign push_addr = ((is_lp | is_lpm) && ptgt == dcs_pkg::REG_SP) ?
                     imm - dcs_pkg::ONE : sp - dcs_pkg::ONE;
  assign push_word = {dcs_pkg::OP_LOAD_IMM, ptgt, 1'b0,
                      push_mark ? dcs_pkg::MK_SEQ : dcs_pkg::MK_NONE,
                      dcs_pkg::PAD_ZERO, push_val};
  assign tgt_gen = tgt > dcs_pkg::REG_P2;
  assign ld_pc = in_exec && do_load && tgt == dcs_pkg::REG_PC;
  assign ld_sp = in_exec && do_load && tgt == dcs_pkg::REG_SP;
  assign ld_rar = in_exec && do_load && tgt == dcs_pkg::REG_RAR;
  assign ld_rcr = in_exec && do_load && tgt == dcs_pkg::REG_RCR;
  assign ld_p2 = in_exec && do_load && tgt == dcs_pkg::REG_P2;

  // ==========================================================
  // Next register values
  logic [17:0] next_pc;
  logic [17:0] next_sp;
  logic [17:0] next_rar;
  logic [17:0] next_rcr;
  logic [17:0] next_p2;
  logic [17:0] fetch_addr;
  // Sequence, unstack and execute fetches bump only the pointer that served them; a repeat fetch bumps none
  assign next_pc = (fetch_done && fmode == dcs_pkg::FM_SEQ) ? pc + dcs_pkg::ONE :
                   (in_exec && do_jump) ? imm :
                   ld_pc ? imm : pc;
  assign next_sp = (fetch_done && fmode == dcs_pkg::FM_UNSTACK) ? sp + dcs_pkg::ONE :
                   (in_exec && do_push) ? push_addr :
                   ld_sp ? imm : sp;
  assign next_rar = (fetch_done && fmode == dcs_pkg::FM_EXEC) ? read_address_register + dcs_pkg::ONE :
                    (in_exec && is_execute_at_address) ? imm :
                    ld_rar ? imm : read_address_register;
  // A load of the count wins over the repeat step
  assign next_rcr = ld_rcr ? imm :
                    (in_exec && fmode == dcs_pkg::FM_REPEAT) ? repeat_count_register + dcs_pkg::ONE : repeat_count_register;
  assign next_p2 = (in_exec && do_push) ? push_val : ld_p2 ? imm : p2;
  assign fetch_addr = (fmode == dcs_pkg::FM_UNSTACK) ? sp :
                      (fmode == dcs_pkg::FM_EXEC) ? read_address_register :
                      (fmode == dcs_pkg::FM_REPEAT) ? last_addr : pc;

  // ==========================================================
  // Fetch mode selection
  // Execute and exhausted repeat fall back to sequence
  assign base_mode = (fmode == dcs_pkg::FM_EXEC) ? dcs_pkg::FM_SEQ :
                     (fmode == dcs_pkg::FM_REPEAT) ?
                     (rcr_more ? dcs_pkg::FM_REPEAT : dcs_pkg::FM_SEQ) : fmode;
  assign mark_mode = (fld == dcs_pkg::MK_UNSTACK) ? dcs_pkg::FM_UNSTACK :
                     (fld == dcs_pkg::MK_SEQ) ? dcs_pkg::FM_SEQ :
                     (fld == dcs_pkg::MK_EXEC) ? dcs_pkg::FM_EXEC :
                     // A repeated word keeps its own repeat mark, so it must not restart the loop
                     (fld == dcs_pkg::MK_REPEAT && fmode != dcs_pkg::FM_REPEAT) ? dcs_pkg::FM_REPEAT :
                     base_mode;
  assign next_fmode = !in_exec ? fmode :
                      is_unstk ? dcs_pkg::FM_UNSTACK :
                      is_execute_at_address ? dcs_pkg::FM_EXEC :
                      has_mode ? mark_mode : base_mode;

  // ==========================================================
  // Channel registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pc <= dcs_pkg::RST_REG;
      sp <= dcs_pkg::RST_REG;
      read_address_register <= dcs_pkg::RST_REG;
      repeat_count_register <= dcs_pkg::RST_REG;
      p2 <= dcs_pkg::RST_REG;
      fmode <= dcs_pkg::FM_SEQ;
    end else begin
      pc <= next_pc;
      sp <= next_sp;
      read_address_register <= next_rar;
      repeat_count_register <= next_rcr;
      p2 <= next_p2;
      fmode <= next_fmode;
    end
  end

  // Remaining registers, status register among them
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < dcs_pkg::NREG; i++) begin
        gen[i] <= dcs_pkg::RST_REG;
      end
    end else if (in_exec && do_load && tgt_gen) begin
      gen[tgt] <= imm;
    end
  end

  // ==========================================================
  // Memory sequencer
  // Request held until acknowledged; memory may stall freely
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= dcs_pkg::ST_ISSUE;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= dcs_pkg::RST_REG;
      mem_wdata_o <= {dcs_pkg::WORD_W{1'b0}};
      ir <= {dcs_pkg::WORD_W{1'b0}};
      last_addr <= dcs_pkg::RST_REG;
    end else begin
      case (st)
        dcs_pkg::ST_ISSUE: begin
          mem_req_o <= 1'b1;
          mem_we_o <= 1'b0;
          mem_addr_o <= fetch_addr;
          last_addr <= fetch_addr;
          st <= dcs_pkg::ST_FWAIT;
        end
        dcs_pkg::ST_FWAIT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            ir <= mem_rdata_i;
            st <= dcs_pkg::ST_EXEC;
          end
        end
        dcs_pkg::ST_EXEC: begin
          if (do_push) begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= push_addr;
            mem_wdata_o <= push_word;
            st <= dcs_pkg::ST_PWAIT;
          end else if (is_slow) begin
            st <= dcs_pkg::ST_SLOW;
          end else begin
            st <= dcs_pkg::ST_ISSUE;
          end
        end
        dcs_pkg::ST_SLOW: begin
          st <= dcs_pkg::ST_ISSUE;
        end
        dcs_pkg::ST_PWAIT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            st <= dcs_pkg::ST_ISSUE;
          end
        end
        default: begin
          mem_req_o <= 1'b0;
          mem_we_o <= 1'b0;
          st <= dcs_pkg::ST_ISSUE;
        end
      endcase
    end
  end

  // ==========================================================
  // Observation outputs, straight from flops
  assign pc_o = pc;
  assign sp_o = sp;
  assign rar_o = read_address_register;
  assign rcr_o = repeat_count_register;
  assign fetch_mode_o = fmode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Stack write that follows a push
  sequence s_push_write;
    mem_req_o && mem_we_o && mem_addr_o == sp;
  endsequence
  // Fetch request from the expected pointer
  sequence s_fetch_from(logic [17:0] a);
    mem_req_o && !mem_we_o && mem_addr_o == a;
  endsequence

  a_push_writes_word: assert property (
    in_exec && do_push |=> s_push_write ##0 mem_wdata_o[17:0] == $past(push_val)
      && mem_wdata_o[35:32] == dcs_pkg::OP_LOAD_IMM)
    else $error("push did not write generated load at pointer");

  a_push_dec_ptr: assert property (
    in_exec && do_push && !((is_lp | is_lpm) && ptgt == dcs_pkg::REG_SP)
      |=> sp == $past(sp) - dcs_pkg::ONE)
    else $error("push did not decrement stack pointer");

  a_push_mark_bit: assert property (
    in_exec && push_mark |=> mem_wdata_o[dcs_pkg::FLD_LSB+:4] == dcs_pkg::MK_SEQ)
    else $error("marked push lacks return mark");

  a_unstack_fetch: assert property (
    st == dcs_pkg::ST_ISSUE && fmode == dcs_pkg::FM_UNSTACK |=> s_fetch_from($past(sp)))
    else $error("unstack fetch not from stack pointer");

  a_seq_pc_inc: assert property (
    fetch_done && fmode == dcs_pkg::FM_SEQ |=> pc == $past(pc) + dcs_pkg::ONE)
    else $error("counter not incremented after fetch");

  a_cond_load_hold: assert property (
    in_exec && is_lif && !cond_ok && tgt == dcs_pkg::REG_RAR |=> read_address_register == $past(read_address_register))
    else $error("conditional load changed register");

  a_jump_target: assert property (
    in_exec && do_jump |=> pc == $past(imm))
    else $error("jump did not load counter");

  a_return_seq: assert property (
    in_exec && fmode == dcs_pkg::FM_UNSTACK && has_mode && fld == dcs_pkg::MK_SEQ
      |=> fmode == dcs_pkg::FM_SEQ ##1 s_fetch_from($past(pc)))
    else $error("return mark did not restore sequential fetch");

  a_exec_at_addr: assert property (
    in_exec && is_execute_at_address |=> read_address_register == $past(imm) && fmode == dcs_pkg::FM_EXEC
      ##1 s_fetch_from($past(imm, 2)))
    else $error("execute at address misbehaved");

  a_rar_inc_use: assert property (
    fetch_done && fmode == dcs_pkg::FM_EXEC |=> read_address_register == $past(read_address_register) + dcs_pkg::ONE)
    else $error("read pointer not incremented on use");

  a_slow_delay: assert property (
    in_exec && is_slow |=> st == dcs_pkg::ST_SLOW ##1 st == dcs_pkg::ST_ISSUE)
    else $error("slow form did not take extra cycle");

  a_reset_mode: assert property (
    @(posedge core_clk_i) $past(rst_i) |-> fmode == dcs_pkg::FM_SEQ && st == dcs_pkg::ST_ISSUE)
    else $error("reset did not give sequential mode");
endmodule

// *** sim/dcs_mem_model.sv ***
module dcs_mem_model (
  // Clock
  input wire logic core_clk_i,
  // Request side
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [17:0] mem_addr_i,
  input wire logic [35:0] mem_wdata_i,
  // Answer side
  output logic mem_ack_o,
  output logic [35:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Storage and answer delay, both set by the bench
  logic [35:0] mem [0:255];
  int delay = 0;
  int wait_cnt = 0;
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 36'h5a5a5a5a5;
  end
  // Answer off the sampling edge; idle data toggles so a stale word never looks valid
  always @(negedge core_clk_i) begin
    if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
      wait_cnt <= 0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (mem_req_i && wait_cnt >= delay) begin
      mem_ack_o <= 1'b1;
      if (mem_we_i) begin
        mem[mem_addr_i[7:0]] <= mem_wdata_i;
      end else begin
        mem_rdata_o <= mem[mem_addr_i[7:0]];
      end
    end else begin
      wait_cnt <= mem_req_i ? wait_cnt + 1 : 0; // Slow answers stall the stealer
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// *** sim/display_channel_sequencer_tb_top.sv ***
module display_channel_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] cond_i = 16'h0000;
  logic mem_req, mem_we, mem_ack;
  logic [17:0] mem_addr, pc, sp, read_address_register, repeat_count_register;
  logic [35:0] wdata, rdata;
  logic [3:0] fmode;
  int mismatches = 0;
  int cmp_count = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // Design and shared memory
  dcs_sequencer uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .mem_req_o(mem_req), .mem_we_o(mem_we),
    .mem_addr_o(mem_addr), .mem_wdata_o(wdata), .mem_ack_i(mem_ack), .mem_rdata_i(rdata),
    .cond_i(cond_i), .pc_o(pc), .sp_o(sp), .rar_o(read_address_register), .rcr_o(repeat_count_register), .fetch_mode_o(fmode));
  dcs_mem_model mdl (.core_clk_i(core_clk_i), .mem_req_i(mem_req), .mem_we_i(mem_we),
    .mem_addr_i(mem_addr), .mem_wdata_i(wdata), .mem_ack_o(mem_ack), .mem_rdata_o(rdata));
  // ==========================================================
  // Helpers
  function automatic logic [35:0] mk(logic [3:0] op, logic [3:0] rg, logic inv, logic [3:0] fld, logic [17:0] d);
    return {op, rg, inv, fld, dcs_pkg::PAD_ZERO, d};
  endfunction
  function automatic logic [35:0] hlt(logic [17:0] a);
    return mk(dcs_pkg::OP_UNCOND_JUMP, dcs_pkg::REG_PC, 1'b0, dcs_pkg::MK_NONE, a);
  endfunction
  task automatic p(input logic [7:0] a, input logic [35:0] w);
    mdl.mem[a] = w;
  endtask
  task automatic chk_reg(input logic [17:0] got, input logic [17:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Wrong paths land on a self loop at fe, so a stray jump shows as a timeout
  task automatic clear_mem;
    for (int i = 0; i < 256; i++) begin
      mdl.mem[i] = hlt(18'h000fe);
    end
  endtask
  task automatic do_reset(input int dly, input logic [15:0] c);
    @(negedge core_clk_i);
    rst_i = 1'b1;
    cond_i = c;
    mdl.delay = dly;
    repeat (5) @(negedge core_clk_i);
    chk_reg(pc, dcs_pkg::RST_REG, "pc in reset");
    chk_reg({14'h0000, fmode}, {14'h0000, dcs_pkg::FM_SEQ}, "mode in reset");
    chk_reg({17'h00000, mem_req}, 18'h00000, "request in reset");
    rst_i = 1'b0;
  endtask
  // Bounded wait for the fetch of the closing self loop
  task automatic run_to(input logic [17:0] a, input string what);
    int n;
    n = 0;
    while (!(mem_req === 1'b1 && mem_we === 1'b0 && mem_addr === a) && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    chk_reg((n < 3000) ? a : 18'h3ffff, a, what);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_loads;
    clear_mem;
    p(8'h00, mk(dcs_pkg::OP_SLOW_LOAD, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h00100));
    p(8'h01, mk(dcs_pkg::OP_COND_LOAD, dcs_pkg::REG_RCR, 1'b0, 4'h2, 18'h00055));
    p(8'h02, mk(dcs_pkg::OP_COND_LOAD, dcs_pkg::REG_RCR, 1'b0, 4'h3, 18'h00077));
    p(8'h03, mk(dcs_pkg::OP_COND_LOAD, dcs_pkg::REG_RCR, 1'b1, 4'h2, 18'h00066));
    p(8'h04, mk(dcs_pkg::OP_COND_LOAD, dcs_pkg::REG_RAR, 1'b1, 4'h3, 18'h000bb));
    p(8'h05, hlt(18'h00005));
    do_reset(0, 16'h0004);
    run_to(18'h00005, "loads end");
    chk_reg(sp, 18'h00100, "slow load");
    chk_reg(repeat_count_register, 18'h00055, "cond load");
    chk_reg(read_address_register, 18'h000bb, "inverted load");
  endtask
  task automatic t_stack;
    clear_mem;
    p(8'h00, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000f0));
    p(8'h01, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_NONE, 18'h00011));
    p(8'h02, mk(dcs_pkg::OP_PUSH_MARK, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_NONE, 18'h00000));
    p(8'h03, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_NONE, 18'h00022));
    p(8'h04, mk(dcs_pkg::OP_PUSH, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_NONE, 18'h00000));
    p(8'h05, mk(dcs_pkg::OP_LOAD_PUSH, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_NONE, 18'h00033));
    p(8'h06, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_NONE, 18'h00099));
    p(8'h07, mk(dcs_pkg::OP_UNSTACK, 4'h0, 1'b0, dcs_pkg::MK_NONE, 18'h00000));
    p(8'h08, hlt(18'h00008));
    do_reset(3, 16'h0000);
    run_to(18'h00008, "unstack end");
    chk_word(mdl.mem[8'hef], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_SEQ, 18'h00011), "mark");
    chk_word(mdl.mem[8'hee], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_NONE, 18'h00022), "push");
    chk_word(mdl.mem[8'hed], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_NONE, 18'h00022), "lpush");
    chk_reg(sp, 18'h000f0, "sp after unstack");
    chk_reg(read_address_register, 18'h00022, "rar restored");
    chk_reg(repeat_count_register, 18'h00011, "rcr restored");
    chk_reg({14'h0000, fmode}, {14'h0000, dcs_pkg::FM_SEQ}, "mode after unstack");
  endtask
  task automatic t_flow;
    clear_mem;
    p(8'h00, hlt(18'h00010));
    p(8'h10, mk(dcs_pkg::OP_SLOW_JUMP, 4'h0, 1'b0, dcs_pkg::MK_NONE, 18'h00020));
    p(8'h20, mk(dcs_pkg::OP_COND_JUMP, 4'h0, 1'b0, 4'h2, 18'h00030));
    p(8'h30, mk(dcs_pkg::OP_COND_JUMP, 4'h0, 1'b0, 4'h3, 18'h00040));
    p(8'h31, mk(dcs_pkg::OP_COND_JUMP, 4'h0, 1'b1, 4'h3, 18'h00050));
    p(8'h50, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000f0));
    p(8'h51, mk(dcs_pkg::OP_CALL, 4'h0, 1'b0, dcs_pkg::MK_NONE, 18'h00060));
    p(8'h60, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_UNSTACK, 18'h00077));
    p(8'h52, hlt(18'h00052));
    do_reset(1, 16'h0004);
    run_to(18'h00052, "flow end");
    chk_word(mdl.mem[8'hef], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_PC, 1'b0, dcs_pkg::MK_SEQ, 18'h00052), "call");
    chk_reg(read_address_register, 18'h00077, "load with mark");
    chk_reg(sp, 18'h000f0, "sp after return");
  endtask
  task automatic t_newstack;
    clear_mem;
    p(8'h00, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000f0));
    p(8'h01, mk(dcs_pkg::OP_LOAD_PUSH, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000c0));
    p(8'h02, mk(dcs_pkg::OP_LOAD_PUSH, dcs_pkg::REG_P2, 1'b0, dcs_pkg::MK_NONE, 18'h00123));
    p(8'h03, mk(dcs_pkg::OP_LOAD_PUSH_MARK, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000a0));
    p(8'h04, hlt(18'h00004));
    do_reset(0, 16'h0000);
    run_to(18'h00004, "new stack end");
    chk_word(mdl.mem[8'hbf], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000f0), "back");
    chk_word(mdl.mem[8'hbe], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_P2, 1'b0, dcs_pkg::MK_NONE, 18'h00123), "temp");
    chk_word(mdl.mem[8'h9f], mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_SEQ, 18'h000be), "mback");
    chk_reg(sp, 18'h0009f, "sp of new stack");
  endtask
  task automatic t_exec;
    clear_mem;
    p(8'h00, mk(dcs_pkg::OP_EXEC_AT, 4'h0, 1'b0, dcs_pkg::MK_NONE, 18'h00040));
    p(8'h40, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_NONE, 18'h00007));
    p(8'h01, mk(dcs_pkg::OP_EXEC_AT, 4'h0, 1'b0, dcs_pkg::MK_NONE, 18'h00048));
    p(8'h48, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_EXEC, 18'h00009));
    p(8'h49, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h00033));
    // Bare mode word enters execute mode; a missed mark falls into the fe loop
    p(8'h02, mk(dcs_pkg::OP_NOP, 4'h0, 1'b0, dcs_pkg::MK_EXEC, 18'h00000));
    p(8'h4a, mk(dcs_pkg::OP_UNCOND_JUMP, 4'h0, 1'b0, dcs_pkg::MK_NONE, 18'h00004));
    p(8'h04, hlt(18'h00004));
    do_reset(2, 16'h0000);
    run_to(18'h00004, "execute end");
    chk_reg(repeat_count_register, 18'h00009, "executed load");
    chk_reg(sp, 18'h00033, "chained execute");
    chk_reg(read_address_register, 18'h0004b, "read pointer steps");
  endtask
  task automatic t_repeat;
    clear_mem;
    p(8'h00, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_SP, 1'b0, dcs_pkg::MK_NONE, 18'h000f0));
    p(8'h01, mk(dcs_pkg::OP_LOAD_IMM, dcs_pkg::REG_RCR, 1'b0, dcs_pkg::MK_NONE, 18'h3fffd));
    p(8'h02, mk(dcs_pkg::OP_PUSH, dcs_pkg::REG_RAR, 1'b0, dcs_pkg::MK_REPEAT, 18'h00000));
    p(8'h03, hlt(18'h00003));
    do_reset(0, 16'h0000);
    run_to(18'h00003, "repeat end");
    // First pass enters repeat, then re-runs at -3, -2 and -1: four pushes in all
    chk_reg(sp, 18'h000ec, "repeated pushes");
    chk_reg(repeat_count_register, 18'h00000, "count ran out");
    chk_reg({14'h0000, fmode}, {14'h0000, dcs_pkg::FM_SEQ}, "mode after repeat");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    t_loads;
    t_stack;
    t_flow;
    t_newstack;
    t_exec;
    t_repeat;
    tally_and_finish;
  end
  initial begin
    #(40000 * 25);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule
